// >>> hw/iess_pkg.sv
// package: register map, field positions, reset values and states
package iess_pkg;
   // ==========================================================
   // register map
   localparam logic [31:0] IESS_ADDR_ENABLE_STATE = 32'hb000_289c;
   localparam logic [31:0] IESS_ADDR_FS_SPIKE = 32'hb000_28a0;
   localparam logic [31:0] IESS_ADDR_HS_SPIKE = 32'hb000_28a4;
   localparam logic [31:0] IESS_ADDR_CONTROL = 32'hb000_28b0;
   localparam logic [31:0] IESS_ADDR_IRQ_STATUS = 32'hb000_28b4;
   localparam logic [31:0] IESS_ADDR_IRQ_MASK = 32'hb000_28b8;
   // ==========================================================
   // field positions
   localparam int IESS_BIT_ACTIVE = 0;
   localparam int IESS_BIT_DWB = 1;
   localparam int IESS_BIT_RXLOST = 2;
   localparam int IESS_BIT_CTL_ENABLE = 0;
   localparam int IESS_BIT_CTL_HS = 1;
   localparam int IESS_IRQ_W = 3;
   // ==========================================================
   // reset values
   localparam logic [7:0] IESS_FS_SPIKE_RST = 8'h07;
   localparam logic [7:0] IESS_HS_SPIKE_RST = 8'h00;
   localparam logic [1:0] IESS_CONTROL_RST = 2'h0;
   localparam logic [IESS_IRQ_W-1:0] IESS_IRQ_MASK_RST = 3'h0;
   localparam logic [31:0] IESS_RDATA_RST = 32'h0000_0000;
   localparam int IESS_NUM_LINES = 2;
   // ==========================================================
   // target-side progress seen by the disable logic
   typedef enum logic [2:0] {
      IESS_ST_IDLE = 3'b000,
      IESS_ST_ADDR = 3'b001,
      IESS_ST_RXDATA = 3'b010,
      IESS_ST_TX = 3'b011,
      IESS_ST_OTHER = 3'b100,
      IESS_ST_DRAIN = 3'b101
   } iess_state_t;
endpackage : iess_pkg

// >>> hw/iess_spike_filter.sv
// one bus line spike filter counted in bus-logic clock cycles
`timescale 1ns/1ps
module iess_spike_filter
   import iess_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic line_in,
   input wire logic [7:0] limit,
   output logic line_out
);
   typedef struct packed {
      logic level;
      logic [7:0] cnt;
   } iess_flt_t;
   iess_flt_t s_q, s_d;

   // ==========================================================
   // filter
   always_comb begin
      s_d = s_q;
      if (line_in == s_q.level) begin
         s_d.cnt = 8'h00;
      end else if (s_q.cnt >= limit) begin
         // stable longer than limit: accept
         s_d.level = line_in; // RQ14
         s_d.cnt = 8'h00;
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{level: 1'b1, cnt: 8'h00};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign line_out = s_q.level;
endmodule : iess_spike_filter

// >>> hw/iess_event_detect.sv
// start and stop condition detector on filtered bus lines
`timescale 1ns/1ps
module iess_event_detect
   import iess_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic clk_f,
   input wire logic dat_f,
   output logic start_det,
   output logic stop_det,
   output logic clk_rise
);
   typedef struct packed {
      logic clk_p;
      logic dat_p;
   } iess_ev_t;
   iess_ev_t s_q, s_d;

   // ==========================================================
   // edge logic
   always_comb begin
      s_d.clk_p = clk_f;
      s_d.dat_p = dat_f;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{clk_p: 1'b1, dat_p: 1'b1};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign start_det = ce && clk_f && s_q.clk_p && s_q.dat_p && !dat_f;
   assign stop_det = ce && clk_f && s_q.clk_p && !s_q.dat_p && dat_f;
   assign clk_rise = ce && clk_f && !s_q.clk_p;
endmodule : iess_event_detect

// >>> hw/iess_top.sv
// enable-state report, abort causes and spike limits of the bus controller
// Operation
// RQ1: enable-state bit 1 until fully inactive
// RQ2: software reads causes after state reads 0
// RQ3: rx-data-lost set on matched data-phase abort
// RQ4: rx-data-lost set on stop after disable
// RQ5: rx-data-lost clear without data phase
// RQ6: disabled-while-busy set during address or rx
// RQ7: disabled-while-busy means a forced nack
// RQ8: disabled-while-busy set on stop after disable
// RQ9: disabled-while-busy clear for idle or other
// RQ10: fs spike limit 8 bits, reset 7
// RQ11: program fs limit before first transfer
// RQ12: hs spike limit 8 bits, reset 0
// RQ13: state and causes update at same point
// RQ14: accept level after stable beyond limit
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module iess_top
   import iess_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic bus_clk_in,
   input wire logic bus_dat_in,
   input wire logic [6:0] own_target_address,
   output logic controller_active_flag,
   output logic target_rx_data_lost,
   output logic target_disabled_while_busy,
   output logic ack_drive_low,
   output logic irq
);
   typedef struct packed {
      logic [31:0] rdata;
      logic [7:0] fs_spike;
      logic [7:0] hs_spike;
      logic [1:0] control;
      logic [IESS_IRQ_W-1:0] irq_status;
      logic [IESS_IRQ_W-1:0] irq_mask;
      logic active;
      logic rxlost;
      logic dwb;
      logic pend_rxlost;
      logic pend_dwb;
      iess_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic is_read;
      logic ack;
      logic irq;
   } iess_regs_t;
   iess_regs_t r_q, r_d;

   // ==========================================================
   // spike filters
   logic [IESS_NUM_LINES-1:0] raw_lines;
   logic [IESS_NUM_LINES-1:0] flt_lines;
   logic [7:0] active_limit;
   logic start_det, stop_det, clk_rise;

   assign raw_lines = {bus_dat_in, bus_clk_in};
   // hs mode selects the separate limit
   assign active_limit = r_q.control[IESS_BIT_CTL_HS] ? r_q.hs_spike : r_q.fs_spike; // RQ12

   genvar gi;
   generate
      for (gi = 0; gi < IESS_NUM_LINES; gi++) begin : g_flt
         iess_spike_filter u_flt (
            .mclk(mclk),
            .nrst(nrst),
            .ce(ce),
            .line_in(raw_lines[gi]),
            .limit(active_limit),
            .line_out(flt_lines[gi])
         );
      end
   endgenerate

   iess_event_detect u_ev (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .clk_f(flt_lines[0]),
      .dat_f(flt_lines[1]),
      .start_det(start_det),
      .stop_det(stop_det),
      .clk_rise(clk_rise)
   );

   // ==========================================================
   // next state
   logic en_ctl;
   logic disabling;
   logic byte_done;
   logic [IESS_IRQ_W-1:0] irq_ev;

   always_comb begin
      r_d = r_q;
      en_ctl = r_q.control[IESS_BIT_CTL_ENABLE];
      disabling = r_q.active && !en_ctl;
      byte_done = 1'b0;
      irq_ev = '0;
      r_d.rdata = IESS_RDATA_RST;

      // --- register writes
      if (wr_en) begin
         case (addr)
            IESS_ADDR_FS_SPIKE: begin
               r_d.fs_spike = wdata[7:0]; // RQ10
            end
            IESS_ADDR_HS_SPIKE: begin
               r_d.hs_spike = wdata[7:0]; // RQ12
            end
            IESS_ADDR_CONTROL: begin
               r_d.control = wdata[1:0];
            end
            IESS_ADDR_IRQ_MASK: begin
               r_d.irq_mask = wdata[IESS_IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // --- bit tracking of the target side
      if (clk_rise && r_q.st != IESS_ST_IDLE) begin
         // the ack slot is not data: keep the byte intact for the decision
         if (r_q.bitcnt != 4'd8) begin
            r_d.shreg = {r_q.shreg[6:0], flt_lines[1]};
         end
         if (r_q.bitcnt == 4'd8) begin
            r_d.bitcnt = 4'd0;
            byte_done = 1'b1;
         end else begin
            r_d.bitcnt = r_q.bitcnt + 4'd1;
         end
      end

      // forced nack while disabling: hold data released during ack slot
      // hold through clock high: releasing early would look like a stop
      r_d.ack = r_q.ack && flt_lines[0];
      if (r_q.bitcnt == 4'd8 && !flt_lines[0] && en_ctl && r_q.active) begin
         r_d.ack = (r_q.st == IESS_ST_ADDR &&
                    r_q.shreg[7:1] == own_target_address) ||
                   r_q.st == IESS_ST_RXDATA;
      end

      if (start_det) begin
         r_d.st = r_q.active ? IESS_ST_ADDR : IESS_ST_OTHER;
         r_d.bitcnt = 4'd0;
      end else if (byte_done) begin
         case (r_q.st)
            IESS_ST_ADDR: begin
               if (r_q.shreg[7:1] != own_target_address || disabling) begin
                  r_d.st = disabling ? IESS_ST_DRAIN : IESS_ST_OTHER;
               end else if (r_q.shreg[0]) begin
                  r_d.st = IESS_ST_TX;
               end else begin
                  r_d.st = IESS_ST_RXDATA;
               end
            end
            IESS_ST_RXDATA: begin
               if (disabling) begin
                  r_d.st = IESS_ST_DRAIN;
               end
            end
            default: begin
            end
         endcase
      end

      // --- disable while busy: record the cause
      if (disabling) begin
         case (r_q.st)
            IESS_ST_ADDR: begin
               r_d.pend_dwb = 1'b1; // RQ6
            end
            IESS_ST_RXDATA: begin
               r_d.pend_dwb = 1'b1; // RQ6
               r_d.pend_rxlost = 1'b1; // RQ3
            end
            IESS_ST_DRAIN: begin
               r_d.pend_dwb = 1'b1; // RQ7
            end
            default: begin
               // idle, tx or other master: keep both as recorded
               r_d.pend_dwb = r_q.pend_dwb; // RQ9
            end
         endcase
      end

      // stop ends the transfer; after disable in address or rx it also sets the causes
      if (stop_det) begin
         if (disabling && (r_q.st == IESS_ST_RXDATA)) begin
            r_d.pend_rxlost = 1'b1; // RQ4
            r_d.pend_dwb = 1'b1; // RQ8
         end else if (disabling && r_q.st == IESS_ST_ADDR) begin
            r_d.pend_dwb = 1'b1; // RQ8
         end
         r_d.st = IESS_ST_IDLE;
      end

      // --- enable state: drop only when no own transfer is open
      if (en_ctl && !r_q.active) begin
         r_d.active = 1'b1;
         r_d.pend_rxlost = 1'b0;
         r_d.pend_dwb = 1'b0;
         r_d.rxlost = 1'b0;
         r_d.dwb = 1'b0;
      end else if (disabling && !r_q.ack
                   && !(r_q.st inside {IESS_ST_ADDR, IESS_ST_RXDATA, IESS_ST_TX})
                   && !(stop_det && r_q.st != IESS_ST_IDLE && r_q.st != IESS_ST_OTHER)) begin
         r_d.active = 1'b0; // RQ1
         // causes settle together with the state bit
         r_d.rxlost = r_d.pend_rxlost; // RQ13
         r_d.dwb = r_d.pend_dwb; // RQ13
         // no data phase: rx-lost stays as recorded, zero otherwise
         r_d.st = IESS_ST_IDLE; // RQ5
         irq_ev[IESS_BIT_ACTIVE] = 1'b1;
         irq_ev[IESS_BIT_DWB] = r_d.pend_dwb;
         irq_ev[IESS_BIT_RXLOST] = r_d.pend_rxlost;
      end

      // --- reads; status cleared by its read, a new event wins
      if (rd_en) begin
         case (addr)
            IESS_ADDR_ENABLE_STATE: begin
               r_d.rdata = {29'h0, r_q.rxlost, r_q.dwb, r_q.active}; // RQ2
            end
            IESS_ADDR_FS_SPIKE: begin
               r_d.rdata = {24'h0, r_q.fs_spike};
            end
            IESS_ADDR_HS_SPIKE: begin
               r_d.rdata = {24'h0, r_q.hs_spike};
            end
            IESS_ADDR_CONTROL: begin
               r_d.rdata = {30'h0, r_q.control};
            end
            IESS_ADDR_IRQ_STATUS: begin
               r_d.rdata = {29'h0, r_q.irq_status};
               r_d.irq_status = '0;
            end
            IESS_ADDR_IRQ_MASK: begin
               r_d.rdata = {29'h0, r_q.irq_mask};
            end
            default: begin
               r_d.rdata = IESS_RDATA_RST;
            end
         endcase
      end
      r_d.irq_status = r_d.irq_status | irq_ev;
      r_d.irq = |(r_d.irq_status & r_d.irq_mask);
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_q <= '{rdata: IESS_RDATA_RST, fs_spike: IESS_FS_SPIKE_RST,
                  hs_spike: IESS_HS_SPIKE_RST, control: IESS_CONTROL_RST,
                  irq_status: '0, irq_mask: IESS_IRQ_MASK_RST, active: 1'b0,
                  rxlost: 1'b0, dwb: 1'b0, pend_rxlost: 1'b0, pend_dwb: 1'b0,
                  st: IESS_ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, is_read: 1'b0,
                  ack: 1'b0, irq: 1'b0};
      end else if (ce) begin
         r_q <= r_d;
      end
   end

   // ==========================================================
   // outputs
   assign rdata = r_q.rdata;
   assign controller_active_flag = r_q.active;
   assign target_rx_data_lost = r_q.rxlost;
   assign target_disabled_while_busy = r_q.dwb;
   assign ack_drive_low = r_q.ack;
   assign irq = r_q.irq;
endmodule : iess_top

// >>> test/iess_checker.sv
// checker: port-level relations of the enable-state block
`timescale 1ns/1ps
module iess_checker
   import iess_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata,
   input wire logic controller_active_flag,
   input wire logic target_rx_data_lost,
   input wire logic target_disabled_while_busy,
   input wire logic ack_drive_low
);
   // ==========
   // short aliases
   wire logic act = controller_active_flag;
   wire logic lost = target_rx_data_lost;
   wire logic dwb = target_disabled_while_busy;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_lost_drop; $rose(lost) |-> $fell(act); endproperty
   a_lost_drop: assert property (p_lost_drop)
      else $error("rx lost rose without active falling");
   property p_dwb_drop; $rose(dwb) |-> $fell(act); endproperty
   a_dwb_drop: assert property (p_dwb_drop)
      else $error("busy cause rose without active falling");
   property p_lost_dwb; lost |-> dwb; endproperty
   a_lost_dwb: assert property (p_lost_dwb)
      else $error("rx lost without busy cause");
   property p_hold; !act ##1 !act |-> $stable({lost, dwb}); endproperty
   a_hold: assert property (p_hold)
      else $error("causes moved while inactive");
   property p_state_rd;
      rd_en && addr == IESS_ADDR_ENABLE_STATE |=>
         rdata == {29'h0, $past(lost), $past(dwb), $past(act)};
   endproperty
   a_state_rd: assert property (p_state_rd)
      else $error("enable state read wrong");
   property p_fs_back;
      wr_en && addr == IESS_ADDR_FS_SPIKE ##1 rd_en && addr == IESS_ADDR_FS_SPIKE
         |=> rdata == {24'h00_0000, $past(wdata[7:0], 2)};
   endproperty
   a_fs_back: assert property (p_fs_back)
      else $error("fs limit readback wrong");
   property p_hs_back;
      wr_en && addr == IESS_ADDR_HS_SPIKE ##1 rd_en && addr == IESS_ADDR_HS_SPIKE
         |=> rdata == {24'h00_0000, $past(wdata[7:0], 2)};
   endproperty
   a_hs_back: assert property (p_hs_back)
      else $error("hs limit readback wrong");
   property p_ack_gate; ack_drive_low |-> act; endproperty
   a_ack_gate: assert property (p_ack_gate)
      else $error("ack driven while inactive");
endmodule : iess_checker
bind iess_top iess_checker u_chk (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .controller_active_flag(controller_active_flag),
   .target_rx_data_lost(target_rx_data_lost), .ack_drive_low(ack_drive_low),
   .target_disabled_while_busy(target_disabled_while_busy));

// >>> test/iess_host_model.sv
// remote bus controller model driving the two bus lines
`timescale 1ns/1ps
module iess_host_model (
   input wire logic mclk,
   output logic bus_clk_in,
   output logic bus_dat_in,
   input wire logic ack_drive_low
);
   // ==========
   // open-drain lines, pulled high when released
   parameter int HALF = 8;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   assign bus_clk_in = scl_q;
   assign bus_dat_in = sda_q & ~ack_drive_low;
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_n
   task automatic start_cond;
      sda_q <= 1'b0;
      wait_n(HALF);
      scl_q <= 1'b0;
      wait_n(HALF);
   endtask : start_cond
   // top n bits of v, msb first; a 1 in the ack slot releases the line
   task automatic send_bits(input logic [8:0] v, input int n);
      for (int i = 8; i > 8 - n; i--) begin
         sda_q <= v[i];
         wait_n(HALF);
         scl_q <= 1'b1;
         wait_n(HALF);
         scl_q <= 1'b0;
      end
   endtask : send_bits
   task automatic stop_cond;
      sda_q <= 1'b0;
      wait_n(HALF);
      scl_q <= 1'b1;
      wait_n(HALF);
      sda_q <= 1'b1;
      wait_n(HALF);
   endtask : stop_cond
   // short low pulse on data while clock is high: a would-be start
   task automatic glitch(input int n);
      sda_q <= 1'b0;
      wait_n(n);
      sda_q <= 1'b1;
      wait_n(2 * HALF);
   endtask : glitch
endmodule : iess_host_model

// >>> test/tb_top.sv
// testbench: register access, disable aborts and spike filtering
`timescale 1ns/1ps
module tb_top;
   import iess_pkg::*;
   // ==========
   // stimulus and bookkeeping
   logic mclk = 0;
   logic nrst = 0;
   logic wr_en = 0;
   logic rd_en = 0;
   logic [31:0] addr = 0;
   logic [31:0] wdata = 0;
   logic [6:0] own = 7'h2a;
   logic [31:0] rdata;
   logic act, lost, dwb, ackl, irq, scl, sda;
   int n_errors = 0;
   int checks = 0;
   always #25 mclk = ~mclk;
   iess_top u_dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .bus_clk_in(scl), .bus_dat_in(sda),
      .own_target_address(own), .controller_active_flag(act), .target_rx_data_lost(lost),
      .target_disabled_while_busy(dwb), .ack_drive_low(ackl), .irq(irq));
   iess_host_model u_host (.mclk(mclk), .bus_clk_in(scl), .bus_dat_in(sda),
      .ack_drive_low(ackl));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      if (n_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr
   // sync=0 issues the read right behind a write, with no gap
   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e, input bit sync);
      if (sync)
         @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 check(n, rdata, e);
   endtask : rd
   // ==========
   // tests
   initial begin
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      rd("state", IESS_ADDR_ENABLE_STATE, 32'h0, 1);
      rd("fs", IESS_ADDR_FS_SPIKE, 32'h0000_0007, 1);
      rd("hs", IESS_ADDR_HS_SPIKE, 32'h0, 1);
      rd("unmapped", 32'hb000_28fc, 32'h0, 1);
      wr(IESS_ADDR_FS_SPIKE, 32'h0000_0102);
      rd("fs", IESS_ADDR_FS_SPIKE, 32'h0000_0002, 0);
      wr(IESS_ADDR_HS_SPIKE, 32'h0000_0003);
      rd("hs", IESS_ADDR_HS_SPIKE, 32'h0000_0003, 0);
      wr(IESS_ADDR_ENABLE_STATE, 32'h0000_0007);
      rd("state ro", IESS_ADDR_ENABLE_STATE, 32'h0, 0);
      // idle disable after a filtered spike, irq masked
      wr(IESS_ADDR_CONTROL, 32'h0000_0001);
      rd("state on", IESS_ADDR_ENABLE_STATE, 32'h0000_0001, 1);
      u_host.glitch(2);
      wr(IESS_ADDR_CONTROL, 32'h0);
      u_host.wait_n(4);
      rd("idle off", IESS_ADDR_ENABLE_STATE, 32'h0, 1);
      check("irq masked", irq, 1'b0);
      rd("irq st", IESS_ADDR_IRQ_STATUS, 32'h0000_0001, 1);
      wr(IESS_ADDR_IRQ_MASK, 32'h0000_0007);
      // disable in the data phase of a matched write
      wr(IESS_ADDR_CONTROL, 32'h0000_0001);
      u_host.start_cond();
      u_host.send_bits({own, 1'b0, 1'b1}, 9);
      u_host.send_bits(9'h14b, 4);
      wr(IESS_ADDR_CONTROL, 32'h0);
      check("draining", act, 1'b1);
      u_host.send_bits(9'h14b << 4, 5);
      u_host.stop_cond();
      rd("rx abort", IESS_ADDR_ENABLE_STATE, 32'h0000_0006, 1);
      check("irq on", irq, 1'b1);
      rd("irq st", IESS_ADDR_IRQ_STATUS, 32'h0000_0007, 1);
      u_host.wait_n(2);
      check("irq off", irq, 1'b0);
      // hs mode: disable during a read address byte
      wr(IESS_ADDR_CONTROL, 32'h0000_0003);
      rd("cleared", IESS_ADDR_ENABLE_STATE, 32'h0000_0001, 1);
      u_host.start_cond();
      u_host.send_bits({own, 1'b1, 1'b1}, 4);
      wr(IESS_ADDR_CONTROL, 32'h0);
      u_host.send_bits({own, 1'b1, 1'b1} << 4, 5);
      u_host.stop_cond();
      rd("tx abort", IESS_ADDR_ENABLE_STATE, 32'h0000_0002, 1);
      give_verdict();
   end
   // the whole run takes about 600 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      give_verdict();
   end
endmodule : tb_top
